// ===== verilog/accel_defines.vh
// register map, field positions, reset values and timing figures for the motion sensor control slice
`ifndef ACCEL_DEFINES_VH
`define ACCEL_DEFINES_VH

// ==========================================
// register offsets
`define REG_X_SAMPLE 8'h00
`define REG_Y_SAMPLE 8'h01
`define REG_Z_SAMPLE 8'h02
`define REG_TILT 8'h03
`define REG_RATE_STATUS 8'h04
`define REG_SLEEP_COUNT 8'h05
`define REG_INT_SETUP 8'h06
`define REG_MODE 8'h07
`define REG_SAMPLE_RATE 8'h08
`define REG_TAP_CONFIG 8'h09

// ==========================================
// reset values
`define RST_BYTE 8'h00
`define RST_SAMPLE 6'h00

// ==========================================
// mode register fields
`define MODE_ACTIVE_BIT 0
`define MODE_TEST_BIT 2
`define MODE_AUTO_WAKE_BIT 3
`define MODE_AUTO_SLEEP_BIT 4
`define MODE_PRESCALE_BIT 5
`define MODE_DRIVE_BIT 6
`define MODE_POLARITY_BIT 7

// ==========================================
// sample rate register fields
`define SR_RUN_LSB 0
`define SR_RUN_MSB 2
`define SR_WAKE_LSB 3
`define SR_WAKE_MSB 4
`define SR_DEBOUNCE_LSB 5
`define SR_DEBOUNCE_MSB 7

// ==========================================
// interrupt setup fields
`define INT_TAP_BIT 2
`define INT_SLEEP_EXIT_BIT 3
`define INT_UPDATE_BIT 4

// ==========================================
// run rate encodings
`define RUN_TAP_FASTEST 3'h0
`define RUN_SIXTY_FOUR 3'h1
`define RUN_THIRTY_TWO 3'h2
`define RUN_SIXTEEN 3'h3

// ==========================================
// timing: figures in ns, counts at the clock rate
`define CLK_MHZ 20
`define RATE0_TIME_NS 8360000
`define RATE1_TIME_NS 15625000
`define RATE2_TIME_NS 31250000
`define RATE3_TIME_NS 62500000
`define WAKE_TIME_NS 31250000
`define TAP_TIME_NS 260000
// the figures above in clock cycles, sized to the counters that hold them
`define RATE0_CYC 21'h28d20
`define RATE1_CYC 21'h4c4b4
`define RATE2_CYC 21'h98968
`define RATE3_CYC 21'h1312d0
`define WAKE_CYC 21'h98968
`define TAP_CYC 13'h1450
`define AVG_COUNT 32
`define AVG_SHIFT 5
`define PRESCALE_LAST 4'hf

// ==========================================
// serial bus target
`define TARGET_ADDR 7'h2a

`endif

// ===== verilog/serial_target.v
// two-wire serial bus target with register pointer and address-acknowledge strobe
`timescale 1ns/1ps
`include "accel_defines.vh"

module serial_target #(
   parameter [6:0] DEV_ADDR = `TARGET_ADDR // arbitrary value
) (
   input wire clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   output reg addr_hit,
   output reg wr_stb,
   output reg rd_stb,
   output reg [7:0] reg_addr,
   output reg [7:0] wr_data,
   input wire [7:0] rd_data
);
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_AACK = 7'h04;
   localparam [6:0] S_WR = 7'h08;
   localparam [6:0] S_WACK = 7'h10;
   localparam [6:0] S_RD = 7'h20;
   localparam [6:0] S_RACK = 7'h40;

   reg [6:0] state_r;
   reg scl_q;
   reg sda_q;
   reg [3:0] cnt_r;
   reg [7:0] shift_r;
   reg rw_r;
   reg first_r;
   reg more_r;
   reg wrote_r;
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire start_c = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_c = scl_in & scl_q & ~sda_q & sda_in;

   // open drain: only ever pulls low
   assign sda_out = 1'b0;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         rw_r <= 1'b0;
         first_r <= 1'b0;
         more_r <= 1'b0;
         wrote_r <= 1'b0;
         sda_oe <= 1'b0;
         addr_hit <= 1'b0;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         reg_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         addr_hit <= 1'b0;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (start_c) begin
            state_r <= S_ADDR;
            cnt_r <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            state_r <= S_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state_r)
               S_ADDR: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], sda_in};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == 4'h8) begin
                     if (shift_r[7:1] == DEV_ADDR) begin
                        // acknowledge slot of our own address
                        state_r <= S_AACK;
                        sda_oe <= 1'b1;
                        addr_hit <= 1'b1;
                        rw_r <= shift_r[0];
                        first_r <= ~shift_r[0];
                     end else begin
                        state_r <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (rw_r) begin
                        state_r <= S_RD;
                        shift_r <= rd_data;
                        rd_stb <= 1'b1;
                        sda_oe <= ~rd_data[7];
                        cnt_r <= 4'h1;
                     end else begin
                        state_r <= S_WR;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               S_WR: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], sda_in};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == 4'h8) begin
                     state_r <= S_WACK;
                     sda_oe <= 1'b1;
                     first_r <= 1'b0;
                     // data bytes only; a pointer byte never advances itself
                     wrote_r <= ~first_r;
                     if (first_r) begin
                        reg_addr <= shift_r;
                     end else begin
                        wr_data <= shift_r;
                        wr_stb <= 1'b1;
                     end
                  end
               end
               S_WACK: begin
                  // pointer advances after the write strobe has been seen
                  if (scl_fall) begin
                     state_r <= S_WR;
                     sda_oe <= 1'b0;
                     cnt_r <= 4'h0;
                     if (wrote_r) begin
                        reg_addr <= reg_addr + 8'h01;
                     end
                  end
               end
               S_RD: begin
                  if (scl_fall) begin
                     if (cnt_r == 4'h8) begin
                        state_r <= S_RACK;
                        sda_oe <= 1'b0;
                        reg_addr <= reg_addr + 8'h01;
                     end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe <= ~shift_r[6];
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     more_r <= ~sda_in;
                  end else if (scl_fall) begin
                     if (more_r) begin
                        state_r <= S_RD;
                        shift_r <= rd_data;
                        rd_stb <= 1'b1;
                        sda_oe <= ~rd_data[7];
                        cnt_r <= 4'h1;
                     end else begin
                        state_r <= S_IDLE;
                     end
                  end
               end
               default: begin
                  state_r <= S_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ===== verilog/accel_rate_and_irq_control.v
// motion sensor control slice: registers, sample timing, auto-wake/sleep, tap detection and event pin
`timescale 1ns/1ps
`include "accel_defines.vh"

module accel_rate_and_irq_control #(
   parameter [20:0] RATE0_CYC = `RATE0_CYC,
   parameter [20:0] RATE1_CYC = `RATE1_CYC,
   parameter [20:0] RATE2_CYC = `RATE2_CYC,
   parameter [20:0] RATE3_CYC = `RATE3_CYC,
   parameter [20:0] WAKE_CYC = `WAKE_CYC,
   parameter [12:0] TAP_CYC = `TAP_CYC
) (
   input wire clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   output reg int_out,
   output reg int_oe,
   input wire [5:0] ax_in,
   input wire [5:0] ay_in,
   input wire [5:0] az_in
);
   localparam [2:0] ST_STBY = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_WAKE = 3'b100;

   // ==========================================
   // serial bus access
   wire addr_hit;
   wire wr_stb;
   wire rd_stb;
   wire [7:0] reg_addr;
   wire [7:0] wr_data;
   reg [7:0] rd_data;

   serial_target u_target (
      .clk(clk),
      .rst(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .addr_hit(addr_hit),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   // ==========================================
   // registers
   reg [7:0] mode_r;
   reg [7:0] sample_rate_config_r;
   reg [7:0] sleep_count_limit_r;
   reg [7:0] int_setup_r;
   reg [4:0] tap_delta_threshold_r;
   reg [17:0] sample_r;
   reg [2:0] state_r;
   reg irq_r;

   wire int_output_drive_sel = mode_r[`MODE_DRIVE_BIT];
   wire int_polarity_sel = mode_r[`MODE_POLARITY_BIT];
   wire auto_wake_en = mode_r[`MODE_AUTO_WAKE_BIT];
   wire auto_sleep_en = mode_r[`MODE_AUTO_SLEEP_BIT];
   wire sleep_prescale_sel = mode_r[`MODE_PRESCALE_BIT];
   wire [2:0] run_rate_sel = sample_rate_config_r[`SR_RUN_MSB:`SR_RUN_LSB];
   wire standby = (state_r == ST_STBY);
   wire mode_wr = wr_stb && reg_addr == `REG_MODE;
   // other registers only change while in standby
   wire cfg_wr = wr_stb && standby;
   wire sleep_reset = mode_wr || (rd_stb && reg_addr == `REG_MODE) || (cfg_wr && reg_addr == `REG_SLEEP_COUNT);

   always @* begin
      if (reg_addr == `REG_X_SAMPLE) begin
         rd_data = {2'b00, sample_r[5:0]};
      end else if (reg_addr == `REG_Y_SAMPLE) begin
         rd_data = {2'b00, sample_r[11:6]};
      end else if (reg_addr == `REG_Z_SAMPLE) begin
         rd_data = {2'b00, sample_r[17:12]};
      end else if (reg_addr == `REG_RATE_STATUS) begin
         rd_data = {6'h00, state_r == ST_WAKE, state_r == ST_RUN};
      end else if (reg_addr == `REG_SLEEP_COUNT) begin
         rd_data = sleep_count_limit_r;
      end else if (reg_addr == `REG_INT_SETUP) begin
         rd_data = int_setup_r;
      end else if (reg_addr == `REG_MODE) begin
         rd_data = mode_r;
      end else if (reg_addr == `REG_SAMPLE_RATE) begin
         rd_data = sample_rate_config_r;
      end else if (reg_addr == `REG_TAP_CONFIG) begin
         rd_data = {3'h0, tap_delta_threshold_r};
      end else begin
         rd_data = 8'h00;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_r <= `RST_BYTE;
         sample_rate_config_r <= `RST_BYTE;
         sleep_count_limit_r <= `RST_BYTE;
         int_setup_r <= `RST_BYTE;
         tap_delta_threshold_r <= 5'h00;
      end else begin
         if (mode_wr) begin
            // active and test may only be entered from standby
            mode_r <= {wr_data[7:3], wr_data[2] & ~mode_r[0] & ~wr_data[0], 1'b0, wr_data[0] & ~mode_r[2]};
         end
         if (cfg_wr && reg_addr == `REG_SAMPLE_RATE) begin
            sample_rate_config_r <= wr_data;
         end
         if (cfg_wr && reg_addr == `REG_SLEEP_COUNT) begin
            sleep_count_limit_r <= wr_data;
         end
         if (cfg_wr && reg_addr == `REG_INT_SETUP) begin
            int_setup_r <= wr_data;
         end
         if (cfg_wr && reg_addr == `REG_TAP_CONFIG) begin
            tap_delta_threshold_r <= wr_data[4:0];
         end
      end
   end

   // ==========================================
   // sample timing: 32 evenly spaced measurements per update
   reg [20:0] period;
   reg [20:0] sub_cnt_r;
   reg [4:0] meas_cnt_r;
   wire [20:0] sub_period = period >> `AVG_SHIFT;
   wire measuring = (state_r == ST_RUN || state_r == ST_WAKE) && !mode_r[`MODE_TEST_BIT];
   wire sub_tick = measuring && sub_cnt_r == sub_period - 21'h1;
   wire upd = sub_tick && meas_cnt_r == 5'h1f;

   always @* begin
      if (state_r == ST_WAKE) begin
         period = WAKE_CYC;
      end else if (run_rate_sel == `RUN_TAP_FASTEST) begin
         period = RATE0_CYC;
      end else if (run_rate_sel == `RUN_SIXTY_FOUR) begin
         period = RATE1_CYC;
      end else if (run_rate_sel == `RUN_THIRTY_TWO) begin
         period = RATE2_CYC;
      end else begin
         period = RATE3_CYC;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sub_cnt_r <= 21'h0;
         meas_cnt_r <= 5'h0;
      end else if (!measuring || mode_wr) begin
         sub_cnt_r <= 21'h0;
         meas_cnt_r <= 5'h0;
      end else if (sub_tick) begin
         sub_cnt_r <= 21'h0;
         meas_cnt_r <= meas_cnt_r + 5'h1;
      end else begin
         sub_cnt_r <= sub_cnt_r + 21'h1;
      end
   end

   // ==========================================
   // per-axis averaging and tap filters
   wire [17:0] axes_in = {az_in, ay_in, ax_in};
   reg [12:0] tap_cnt_r;
   wire tap_en = state_r == ST_RUN && run_rate_sel == `RUN_TAP_FASTEST && measuring;
   wire tap_tick = tap_en && tap_cnt_r == TAP_CYC - 13'h1;
   wire [2:0] over;
   reg tap_seen_r;
   wire tap_hit = (|over) && !tap_seen_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tap_cnt_r <= 13'h0;
         tap_seen_r <= 1'b0;
      end else begin
         tap_cnt_r <= (!tap_en || tap_tick) ? 13'h0 : tap_cnt_r + 13'h1;
         if (tap_tick || !tap_en) begin
            tap_seen_r <= tap_en && (|over);
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_axis
         reg [10:0] acc_r;
         reg [5:0] last_r;
         reg [5:0] fast_r;
         reg [8:0] slow_r;
         wire [5:0] cur = axes_in[i*6 +: 6];
         wire [6:0] pair = {1'b0, cur} + {1'b0, last_r};
         wire [5:0] slow_v = slow_r[8:3];
         wire [5:0] diff = (fast_r > slow_v) ? fast_r - slow_v : slow_v - fast_r;
         wire [10:0] acc_sum = acc_r + {5'h00, cur};
         assign over[i] = tap_en && diff > {1'b0, tap_delta_threshold_r};
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               acc_r <= 11'h0;
               last_r <= 6'h0;
               fast_r <= 6'h0;
               slow_r <= 9'h0;
               sample_r[i*6 +: 6] <= `RST_SAMPLE;
            end else begin
               if (mode_wr) begin
                  sample_r[i*6 +: 6] <= `RST_SAMPLE;
                  acc_r <= 11'h0;
               end else if (upd) begin
                  sample_r[i*6 +: 6] <= acc_sum[10:5];
                  acc_r <= 11'h0;
               end else if (sub_tick) begin
                  acc_r <= acc_sum;
               end
               if (tap_tick) begin
                  // fast: current and last; slow: one-eighth weight leaky average
                  last_r <= cur;
                  fast_r <= pair[6:1];
                  slow_r <= slow_r - {3'h0, slow_v} + {3'h0, cur};
               end
            end
         end
      end
   endgenerate

   // ==========================================
   // auto-wake / auto-sleep state and sleep counter
   reg [3:0] pre_cnt_r;
   reg [7:0] sleep_cnt_r;
   wire sleep_tick = upd && state_r == ST_RUN && auto_sleep_en &&
                     (!sleep_prescale_sel || pre_cnt_r == `PRESCALE_LAST);
   wire [7:0] sleep_cnt_inc = sleep_cnt_r + 8'h01;
   wire sleep_exit = sleep_tick && sleep_cnt_inc == sleep_count_limit_r;
   wire int_event = (int_setup_r[`INT_UPDATE_BIT] && upd) || (int_setup_r[`INT_TAP_BIT] && tap_hit) ||
                    (int_setup_r[`INT_SLEEP_EXIT_BIT] && sleep_exit);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_STBY;
         pre_cnt_r <= 4'h0;
         sleep_cnt_r <= 8'h00;
      end else begin
         if (sleep_reset || state_r != ST_RUN || int_event) begin
            pre_cnt_r <= 4'h0;
            sleep_cnt_r <= 8'h00;
         end else if (upd && auto_sleep_en) begin
            pre_cnt_r <= pre_cnt_r + 4'h1;
            if (sleep_tick) begin
               sleep_cnt_r <= sleep_exit ? 8'h00 : sleep_cnt_inc;
            end
         end
         case (state_r)
            ST_STBY: begin
               if (mode_r[`MODE_ACTIVE_BIT]) begin
                  state_r <= (auto_wake_en && !auto_sleep_en) ? ST_WAKE : ST_RUN;
               end
            end
            ST_RUN: begin
               if (!mode_r[`MODE_ACTIVE_BIT]) begin
                  state_r <= ST_STBY;
               end else if (auto_wake_en && !auto_sleep_en) begin
                  state_r <= ST_WAKE;
               end else if (sleep_exit) begin
                  state_r <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (!mode_r[`MODE_ACTIVE_BIT]) begin
                  state_r <= ST_STBY;
               end else if (!auto_wake_en && !auto_sleep_en) begin
                  state_r <= ST_RUN;
               end else if (auto_sleep_en && int_event) begin
                  state_r <= ST_RUN;
               end
            end
            default: begin
               state_r <= ST_STBY;
            end
         endcase
      end
   end

   // ==========================================
   // event pin: a new event wins over a release in the same cycle
   wire level = int_polarity_sel ? irq_r : ~irq_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
         int_out <= 1'b0;
         int_oe <= 1'b0;
      end else begin
         if (int_event) begin
            irq_r <= 1'b1;
         end else if (addr_hit) begin
            irq_r <= 1'b0;
         end
         // open-drain only ever pulls low; the line floats high otherwise
         int_out <= int_output_drive_sel ? level : 1'b0;
         int_oe <= int_output_drive_sel ? 1'b1 : ~level;
      end
   end
endmodule

// ===== tb/accel_ctl_asserts.sv
// port assertions for the motion sensor control slice
`timescale 1ns/1ps
module accel_ctl_asserts (
   input wire clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire int_out,
   input wire int_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // =====
   // serial data line
   a_sda_never_high: assert property (sda_out == 1'b0) else $error("data line driven high");
   a_ack_launch: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in) && $past(scl_in, 2))
      else $error("data line taken off clock low");
   a_free_scl_low: assert property ($fell(sda_oe) |-> !scl_in) else $error("data line freed with clock high");
   a_steady_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data line moved with clock high");
   a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*4]) else $error("ack dropped early");
   a_start_free: assert property (scl_in && $past(scl_in) && $changed(sda_in) |-> !sda_oe)
      else $error("device on line at start or stop");
   // =====
   // event pin, and both pins after reset
   a_od_never_high: assert property (int_out |-> int_oe) else $error("pin high while undriven");
   a_reset_idle: assert property ($fell(rst) |-> !int_oe && !sda_oe) else $error("pins busy after reset");
endmodule
bind accel_rate_and_irq_control accel_ctl_asserts chk_i (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe));

// ===== tb/serial_host_model.sv
// two-wire serial bus host; clock idles high between frames
`timescale 1ns/1ps
module serial_host_model (
   input wire clk,
   input wire sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // =====
   // each step changes lines at an edge, then holds them
   task automatic step(input logic c, input logic l, input int n);
      scl <= c;
      sda_low <= l;
      repeat (n) @(posedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, sda_low, 2);
      step(1'b0, !b, 2);
      step(1'b1, !b, 4);
      r = sda;
   endtask
   // nine-bit unit: eight data bits then the acknowledge slot
   task automatic xb(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) bit_io(w[i], r[i]);
   endtask
   task automatic frame(input logic a, input logic b);
      @(posedge clk);
      step(1'b0, sda_low, 2);
      step(1'b0, a, 2);
      step(1'b1, a, 4);
      step(1'b1, b, 4);
   endtask
endmodule

// ===== tb/accel_rate_and_irq_control_bench.sv
// self-checking bench: register access, sample rates, event pin and sleep states
`timescale 1ns/1ps
`include "accel_defines.vh"
module accel_rate_and_irq_control_bench;
   logic clk, rst;
   logic [5:0] ax, ay, az;
   wire sda_out, sda_oe, int_out, int_oe, scl, sda_low;
   wire sda = !(sda_low || sda_oe);
   wire pin = int_oe ? int_out : 1'b1;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int t0, t1;
   int rc [4] = '{32'h280, 32'h500, 32'ha00, 32'h1400};
   logic [7:0] sm [5] = '{8'h01, 8'h09, 8'h11, 8'h31, 8'h31};
   logic [7:0] sl [5] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h01};
   logic [7:0] se [5] = '{8'h01, 8'h02, 8'h02, 8'h01, 8'h02};
   int sw [5] = '{32'h780, 32'h780, 32'h780, 32'h780, 32'h2a00};
   logic [7:0] mdl [0:9];
   logic [7:0] seed = 8'h1d;
   logic [8:0] ak;
   logic [7:0] d, md;
   accel_rate_and_irq_control #(.RATE0_CYC(21'h280), .RATE1_CYC(21'h500), .RATE2_CYC(21'ha00),
      .RATE3_CYC(21'h1400), .TAP_CYC(13'h14)) dut (.clk(clk), .rst(rst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
      .ax_in(ax), .ay_in(ay), .az_in(az));
   serial_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // =====
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host.frame(1'b0, 1'b1);
      host.xb({`TARGET_ADDR, 2'b01}, ak);
      host.xb({a, 1'b1}, ak);
      host.xb({v, 1'b1}, ak);
      host.frame(1'b1, 1'b0);
      mdl[a] = v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      host.frame(1'b0, 1'b1);
      host.xb({`TARGET_ADDR, 2'b01}, ak);
      host.xb({a, 1'b1}, ak);
      host.frame(1'b0, 1'b1);
      host.xb({`TARGET_ADDR, 2'b11}, ak);
      host.xb(9'h1ff, ak);
      host.frame(1'b1, 1'b0);
      v = ak[8:1];
   endtask
   task automatic wait_pin(input logic lv, output int t);
      for (int n = 0; pin !== lv && n < 32'h4000; n++) @(negedge clk);
      t = cyc;
   endtask
   // expected drive and enable of the event pin from polarity and drive select
   task automatic pin_chk(input logic act);
      logic lv;
      @(negedge clk);
      lv = md[7] ~^ act;
      chk({int_oe, int_out}, md[6] ? {1'b1, lv} : {!lv, 1'b0});
   endtask
   // =====
   // main sequence
   initial begin
      rst = 1'b1;
      ax = 6'h00;
      ay = 6'h00;
      az = 6'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(8'h08, d);
      chk(d, 8'h00);
      repeat (3) begin
         seed = lfsr(seed);
         wr(8'h08, seed);
         rd(8'h08, d);
         chk(d, mdl[8]);
      end
      $display("test register access done");
      for (int r = 0; r < 4; r++) begin
         seed = lfsr(seed);
         @(posedge clk);
         ax <= seed[5:0];
         ay <= seed[7:2];
         az <= ~seed[5:0];
         md = {r[0], r[0] ^ r[1], 6'h01};
         wr(8'h08, {5'h00, r[2:0]});
         wr(8'h06, 8'h10);
         wr(8'h07, md);
         wait_pin(md[7], t0);
         pin_chk(1'b1);
         rd(8'h00, d);
         pin_chk(1'b0);
         chk(d, {2'b00, ax});
         wait_pin(md[7], t1);
         chk(t1 - t0, rc[r]);
         rd(8'h01, d);
         chk(d, {2'b00, ay});
         rd(8'h02, d);
         chk(d, {2'b00, az});
         wr(8'h07, 8'h00);
         rd(8'h00, d);
         chk(d, 8'h00);
         $display("test rate %0d done", r);
      end
      for (int i = 0; i < 5; i++) begin
         wr(8'h07, 8'h00);
         wr(8'h08, 8'h00);
         wr(8'h06, 8'h00);
         wr(8'h05, sl[i]);
         wr(8'h07, sm[i]);
         repeat (sw[i]) @(posedge clk);
         rd(8'h04, d);
         chk(d, se[i]);
         $display("test sleep state %0d done", i);
      end
      // tap with both auto modes set: settle filters on a flat input, then one large step
      wr(8'h07, 8'h00);
      wr(8'h05, 8'h00);
      wr(8'h09, 8'h1f);
      wr(8'h06, 8'h04);
      md = 8'h19;
      @(posedge clk);
      ax <= 6'h00;
      ay <= 6'h00;
      az <= 6'h00;
      wr(8'h07, md);
      repeat (1000) @(posedge clk);
      rd(8'h09, d);
      chk(d, mdl[9]);
      pin_chk(1'b0);
      @(posedge clk);
      ax <= 6'h3f;
      t1 = cyc;
      wait_pin(md[7], t0);
      pin_chk(1'b1);
      chk(t0 - t1 < 48, 1);
      $display("test tap done");
      print_verdict();
   end
   initial begin
      repeat (32'h15f90) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
endmodule
